// File: logic/ufu_pkg.sv
// Shared constants for the upstream USB 2.0 front end control block
package ufu_pkg;

    // ==================================================================
    // Register map (byte addresses)
    // ==================================================================
    localparam logic [7:0]  CTRL_OFFSET      = 8'hc8;
    localparam logic [7:0]  IRQ_STAT_OFFSET  = 8'hcc;
    localparam logic [7:0]  IRQ_MASK_OFFSET  = 8'hd0;

    // ==================================================================
    // Control register field positions
    // ==================================================================
    localparam int          TERM_EN_BIT      = 29;
    localparam int          SQUELCH_B_BIT    = 28;
    localparam int          DISC_BIT         = 27;
    localparam int          TUNE_LSB         = 24;
    localparam int          TUNE_W           = 3;
    localparam int          CTRL_LANE        = 3;

    // ==================================================================
    // Interrupt status / mask layout
    // ==================================================================
    localparam int          EVT_W            = 2;
    localparam int          EVT_DISC_BIT     = 0;
    localparam int          EVT_SQUELCH_BIT  = 1;
    localparam int          EVT_LANE         = 0;

    // ==================================================================
    // Reset values
    // ==================================================================
    localparam logic            TERM_EN_RST  = 1'b0;
    localparam logic [2:0]      TUNE_RST     = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST     = 2'h0;
    localparam logic [31:0]     ZERO_WORD    = 32'h0000_0000;

endpackage

// File: logic/ufu_tune_if.sv
// Link between the register bank and the squelch tune keeper
`timescale 1ns/100ps
interface ufu_tune_if;
    logic       wr_stb;     // Software write of the tune field
    logic [2:0] wr_data;
    logic [2:0] tune;       // Live tune value

    modport bank   (output wr_stb, output wr_data, input tune);
    modport keeper (input wr_stb, input wr_data, output tune);
endinterface

// File: logic/ufu_tune_keeper.sv
// Squelch tune field with image capture and restore
`timescale 1ns/100ps
module ufu_tune_keeper (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       image_load,
    input  wire logic       eeprom_present,
    input  wire logic [2:0] config_squelch_threshold,
    input  wire logic       otp_programmed,
    input  wire logic [2:0] otp_squelch_threshold,
    input  wire logic       usb_reset,
    input  wire logic       lite_reset,
    ufu_tune_if.keeper      tif
);

    logic [2:0] image_q;
    logic [2:0] image_d;
    logic [2:0] tune_q;

    // ==================================================================
    // Image source selection
    // ==================================================================
    // EEPROM first, then OTP, else zero
    always_comb begin
        if (eeprom_present) begin
            image_d = config_squelch_threshold;
        end else if (otp_programmed) begin
            image_d = otp_squelch_threshold;
        end else begin
            image_d = ufu_pkg::TUNE_RST;
        end
    end

    // Latch the image each time the configuration is loaded
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            image_q <= ufu_pkg::TUNE_RST;
        end else if (image_load) begin
            image_q <= image_d;
        end
    end

    // ==================================================================
    // Live tune field
    // ==================================================================
    // Bus resets restore the image; protected resets never reach here
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tune_q <= ufu_pkg::TUNE_RST;
        end else if (image_load) begin
            tune_q <= image_d;
        end else if (usb_reset || lite_reset) begin
            tune_q <= image_q;
        end else if (tif.wr_stb) begin
            tune_q <= tif.wr_data;
        end
    end

    assign tif.tune = tune_q;

endmodule

// File: logic/ufu_afe_ctrl.sv
// Upstream USB 2.0 front end control register bank on classic Wishbone
`timescale 1ns/100ps

// What this block does
// - Bit 29 is read/write high-speed termination enable, zero after reset.
// - Bit 28 reads the active-low squelch state; zero means data valid.
// - Bit 27 reads the high-speed disconnect state; one means disconnected.
// - Bits 26:24 hold a read/write squelch trip-point tune code.
// - A protected reset leaves the squelch tune field untouched.
// - Tune default comes from EEPROM, else OTP, else zero.
// - USB reset or lite reset restores tune from the last loaded image.
module ufu_afe_ctrl (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Resets and configuration image
    input  wire logic        protected_reset,
    input  wire logic        usb_reset,
    input  wire logic        lite_reset,
    input  wire logic        image_load,
    input  wire logic        eeprom_present,
    input  wire logic [2:0]  config_squelch_threshold,
    input  wire logic        otp_programmed,
    input  wire logic [2:0]  otp_squelch_threshold,
    // Analog front end
    input  wire logic        afe_squelch_active_low,
    input  wire logic        afe_disconnect,
    output logic             hs_termination_enable,
    output logic      [2:0]  squelch_trip_tune,
    // Interrupt
    output logic             irq
);

    // ==================================================================
    // Declarations
    // ==================================================================
    // Bus handshake and read data
    logic                       ack_q;
    logic [31:0]                rdata_q;
    // Control field and front end state
    logic                       term_en_q;
    logic [1:0]                 sq_sync_q;
    logic [1:0]                 disc_sync_q;
    logic                       sq_prev_q;
    logic                       disc_prev_q;
    // Events, status and mask
    logic [ufu_pkg::EVT_W-1:0]  stat_q;
    logic [ufu_pkg::EVT_W-1:0]  mask_q;
    logic [ufu_pkg::EVT_W-1:0]  evt_set;
    logic [ufu_pkg::EVT_W-1:0]  stat_clr;
    logic                       disc_rise;
    logic                       sq_change;
    // Decode and write strobes
    logic                       req;
    logic                       wr_take;
    logic                       hit_ctrl;
    logic                       hit_stat;
    logic                       hit_mask;
    logic [31:0]                rd_word;
    logic                       wr_ctrl;
    logic                       wr_stat;
    logic                       wr_mask;

    // Carries tune writes to the keeper and the live value back
    ufu_tune_if tif ();

    // Build the control word from live state
    function automatic logic [31:0] ctrl_word(input logic       term,
                                              input logic       sq_b,
                                              input logic       disc,
                                              input logic [2:0] tune);
        logic [31:0] w;
        w = ufu_pkg::ZERO_WORD;
        w[ufu_pkg::TERM_EN_BIT]   = term;
        w[ufu_pkg::SQUELCH_B_BIT] = sq_b;
        w[ufu_pkg::DISC_BIT]      = disc;
        w[ufu_pkg::TUNE_LSB +: ufu_pkg::TUNE_W] = tune;
        return w;
    endfunction

    // ==================================================================
    // Helper functions
    // ==================================================================
    // Exact byte address match; sub-word offsets never decode
    function automatic logic addr_hit(input logic [7:0] adr,
                                      input logic [7:0] offset);
        return adr == offset;
    endfunction

    // Write strobe for one register, gated by the lane holding its fields
    function automatic logic lane_write(input logic       take,
                                        input logic       hit,
                                        input logic [3:0] sel,
                                        input int         lane);
        return take && hit && sel[lane];
    endfunction

    // Event bits at the bottom of an otherwise zero word
    function automatic logic [31:0] evt_word(input logic [ufu_pkg::EVT_W-1:0] bits);
        logic [31:0] w;
        w = ufu_pkg::ZERO_WORD;
        w[ufu_pkg::EVT_W-1:0] = bits;
        return w;
    endfunction

    // ==================================================================
    // Bus handshake
    // ==================================================================
    // A new request is one not yet answered; gating with ack keeps a
    // request still held in the ack cycle from being taken twice
    assign req     = wb_cyc_i && wb_stb_i && !ack_q;
    // Writes take effect at the edge where the master sees ack, while
    // address, lanes and data are still held
    assign wr_take = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;

    // Address decode; addresses outside the map hit nothing
    always_comb begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        if (addr_hit(wb_adr_i, ufu_pkg::CTRL_OFFSET)) begin
            hit_ctrl = 1'b1;
        end else if (addr_hit(wb_adr_i, ufu_pkg::IRQ_STAT_OFFSET)) begin
            hit_stat = 1'b1;
        end else if (addr_hit(wb_adr_i, ufu_pkg::IRQ_MASK_OFFSET)) begin
            hit_mask = 1'b1;
        end
    end

    // Lane-qualified write strobes; control fields sit in the top byte,
    // event bits in the bottom byte
    assign wr_ctrl = lane_write(wr_take, hit_ctrl, wb_sel_i, ufu_pkg::CTRL_LANE);
    assign wr_stat = lane_write(wr_take, hit_stat, wb_sel_i, ufu_pkg::EVT_LANE);
    assign wr_mask = lane_write(wr_take, hit_mask, wb_sel_i, ufu_pkg::EVT_LANE);

    // Read mux; unmapped addresses read zero
    // Status and mask share one layout at the bottom of the word
    always_comb begin
        rd_word = ufu_pkg::ZERO_WORD;
        if (hit_ctrl) begin
            rd_word = ctrl_word(term_en_q, sq_sync_q[1], disc_sync_q[1], tif.tune);
        end else if (hit_stat) begin
            rd_word = evt_word(stat_q);
        end else if (hit_mask) begin
            rd_word = evt_word(mask_q);
        end
    end

    // One wait state, ack for one cycle
    // The answer comes one cycle after the take for every address
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read data captured as the request is taken; it stands in the
    // ack cycle and holds until the next request
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_q <= ufu_pkg::ZERO_WORD;
        end else if (req) begin
            rdata_q <= rd_word;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ==================================================================
    // Control fields
    // ==================================================================
    // Termination enable; cleared by full and protected reset alike
    // The tune field is absent here on purpose: it survives protection
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            term_en_q <= ufu_pkg::TERM_EN_RST;
        end else if (protected_reset) begin
            term_en_q <= ufu_pkg::TERM_EN_RST;
        end else if (wr_ctrl) begin
            term_en_q <= wb_dat_i[ufu_pkg::TERM_EN_BIT];
        end
    end

    // Drives the termination switch on both data lines directly
    assign hs_termination_enable = term_en_q;

    // Tune writes pass to the keeper; protected reset is not routed there
    // The live tune value returns through the interface to the pin
    assign tif.wr_stb  = wr_ctrl;
    assign tif.wr_data = wb_dat_i[ufu_pkg::TUNE_LSB +: ufu_pkg::TUNE_W];
    assign squelch_trip_tune = tif.tune;

    // Tune field storage, image capture and restore
    // The keeper sees no protected reset, which keeps the tune value
    // across one; only full reset, image load, bus resets and tune writes move it
    ufu_tune_keeper u_keeper (
        .clock                    (clock),
        .rst_b                    (rst_b),
        .image_load               (image_load),
        .eeprom_present           (eeprom_present),
        .config_squelch_threshold (config_squelch_threshold),
        .otp_programmed           (otp_programmed),
        .otp_squelch_threshold    (otp_squelch_threshold),
        .usb_reset                (usb_reset),
        .lite_reset               (lite_reset),
        .tif                      (tif)
    );

    // ==================================================================
    // Front end status inputs
    // ==================================================================
    // Two-flop synchronisers on the analog status lines; squelch resets
    // high and disconnect low, the levels of an idle line, so leaving
    // reset on a quiet bus raises no event
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sq_sync_q   <= 2'h3;
            disc_sync_q <= 2'h0;
        end else begin
            sq_sync_q   <= {sq_sync_q[0], afe_squelch_active_low};
            disc_sync_q <= {disc_sync_q[0], afe_disconnect};
        end
    end

    // Previous synchronised values for edge detection
    // Reset to the same levels as the synchronisers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sq_prev_q   <= 1'b1;
            disc_prev_q <= 1'b0;
        end else begin
            sq_prev_q   <= sq_sync_q[1];
            disc_prev_q <= disc_sync_q[1];
        end
    end

    // Disconnect event is the synchronised line going high; the level
    // only means something at end of a high-speed packet, so the event
    // is a hint that the consumer qualifies at the right bit time
    assign disc_rise = disc_sync_q[1] && !disc_prev_q;

    // Squelch event is any change of the synchronised state, so both
    // start and end of valid data are seen
    assign sq_change = sq_sync_q[1] != sq_prev_q;

    // Gather the events into the status layout
    always_comb begin
        evt_set = ufu_pkg::EVT_RST;
        evt_set[ufu_pkg::EVT_DISC_BIT]    = disc_rise;
        evt_set[ufu_pkg::EVT_SQUELCH_BIT] = sq_change;
    end

    // ==================================================================
    // Interrupt status and mask
    // ==================================================================
    // Write one to clear, byte lane 0; written zeros leave bits alone
    // Only lane 0 carries event bits
    always_comb begin
        stat_clr = ufu_pkg::EVT_RST;
        if (wr_stat) begin
            stat_clr = wb_dat_i[ufu_pkg::EVT_W-1:0];
        end
    end

    // Sticky status; a set in the clear cycle wins, so an event that
    // lands as software clears is never lost
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stat_q <= ufu_pkg::EVT_RST;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | evt_set;
        end
    end

    // Mask register; a set bit lets its status bit drive the interrupt
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mask_q <= ufu_pkg::EVT_RST;
        end else if (wr_mask) begin
            mask_q <= wb_dat_i[ufu_pkg::EVT_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set; both inputs
    // are registers, so the line is glitch free and drops in the cycle
    // after the last unmasked bit is cleared
    assign irq = |(stat_q & mask_q);

endmodule

// File: verif/ufu_afe_model.sv
// Behavioural analog front end and upstream lines facing the control block
`timescale 1ns/100ps
module ufu_afe_model (
    input  wire logic clock,
    input  wire logic traffic,
    input  wire logic unplugged,
    input  wire logic hs_termination_enable,
    output logic      afe_squelch_active_low,
    output logic      afe_disconnect
);
    // ==================================================================
    // Line state
    // ==================================================================
    // Squelch pin reads high (invalid) unless the host is sending
    always_ff @(posedge clock) afe_squelch_active_low <= !traffic;
    // Disconnect only seen with high-speed termination on, held as an end-of-packet level
    always_ff @(posedge clock) afe_disconnect <= unplugged && hs_termination_enable;
endmodule

// File: verif/ufu_afe_ctrl_chk.sv
// Concurrent checks on the ports of the front end control block
`timescale 1ns/100ps
module ufu_afe_ctrl_chk (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        protected_reset,
    input wire logic        usb_reset,
    input wire logic        lite_reset,
    input wire logic        image_load,
    input wire logic        eeprom_present,
    input wire logic [2:0]  config_squelch_threshold,
    input wire logic        otp_programmed,
    input wire logic [2:0]  otp_squelch_threshold,
    input wire logic        afe_squelch_active_low,
    input wire logic        afe_disconnect,
    input wire logic        hs_termination_enable,
    input wire logic [2:0]  squelch_trip_tune
);
    // ==================================================================
    // Helper logic
    // ==================================================================
    logic       rd_ctrl, wr_ctrl, tune_busy;
    logic [2:0] cand_d, wr_tune, last_img_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Completed control accesses and the image source in priority order
    assign rd_ctrl = wb_ack_o && !wb_we_i && wb_adr_i == ufu_pkg::CTRL_OFFSET;
    assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[ufu_pkg::CTRL_LANE] && wb_adr_i == ufu_pkg::CTRL_OFFSET;
    assign wr_tune = wb_dat_i[ufu_pkg::TUNE_LSB +: ufu_pkg::TUNE_W];
    assign tune_busy = image_load || usb_reset || lite_reset;
    assign cand_d = eeprom_present ? config_squelch_threshold : (otp_programmed ? otp_squelch_threshold : 3'h0);
    // Last captured image, the value a restore must bring back
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            last_img_q <= 3'h0;
        end else if (image_load) begin
            last_img_q <= cand_d;
        end
    end
    sequence quiet_s(sig);
        $stable(sig) [*5];
    endsequence
    // ==================================================================
    // Assertions
    // ==================================================================
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    term_write_a: assert property (wr_ctrl && !protected_reset |=>
        hs_termination_enable == $past(wb_dat_i[ufu_pkg::TERM_EN_BIT])) else $error("term enable write lost");
    tune_write_a: assert property (wr_ctrl && !tune_busy |=>
        squelch_trip_tune == $past(wr_tune)) else $error("tune write lost");
    reserved_zero_a: assert property (rd_ctrl |-> wb_dat_o[31:30] == 2'h0 && wb_dat_o[23:0] == 24'h0)
        else $error("reserved bits not zero");
    protect_keep_a: assert property (protected_reset && !tune_busy && !wr_ctrl |=>
        !hs_termination_enable && $stable(squelch_trip_tune)) else $error("protected reset wrong");
    image_load_a: assert property (image_load |=> squelch_trip_tune == $past(cand_d))
        else $error("image not loaded into tune");
    restore_a: assert property ((usb_reset || lite_reset) && !image_load |=> squelch_trip_tune == last_img_q)
        else $error("tune not restored");
    squelch_read_a: assert property (quiet_s(afe_squelch_active_low) ##0 rd_ctrl |->
        wb_dat_o[ufu_pkg::SQUELCH_B_BIT] == afe_squelch_active_low) else $error("squelch bit wrong");
    disc_read_a: assert property (quiet_s(afe_disconnect) ##0 rd_ctrl |->
        wb_dat_o[ufu_pkg::DISC_BIT] == afe_disconnect) else $error("disconnect bit wrong");
endmodule
bind ufu_afe_ctrl ufu_afe_ctrl_chk u_ufu_afe_ctrl_chk (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .protected_reset(protected_reset), .usb_reset(usb_reset), .lite_reset(lite_reset), .image_load(image_load),
    .eeprom_present(eeprom_present), .config_squelch_threshold(config_squelch_threshold),
    .otp_programmed(otp_programmed), .otp_squelch_threshold(otp_squelch_threshold),
    .afe_squelch_active_low(afe_squelch_active_low), .afe_disconnect(afe_disconnect),
    .hs_termination_enable(hs_termination_enable), .squelch_trip_tune(squelch_trip_tune));

// File: verif/tb_top.sv
// Self-checking bench for the front end control register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic        clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, traffic, unplugged;
    logic        protected_reset, usb_reset, lite_reset, image_load, eeprom_present, otp_programmed;
    logic        afe_squelch_active_low, afe_disconnect, hs_termination_enable;
    logic [2:0]  config_squelch_threshold, otp_squelch_threshold, squelch_trip_tune;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int          checks, miscompares, i;
    // Design and line model
    ufu_afe_ctrl u_ufu_afe_ctrl (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .protected_reset(protected_reset), .usb_reset(usb_reset), .lite_reset(lite_reset),
        .image_load(image_load), .eeprom_present(eeprom_present), .config_squelch_threshold(config_squelch_threshold),
        .otp_programmed(otp_programmed), .otp_squelch_threshold(otp_squelch_threshold),
        .afe_squelch_active_low(afe_squelch_active_low), .afe_disconnect(afe_disconnect),
        .hs_termination_enable(hs_termination_enable), .squelch_trip_tune(squelch_trip_tune), .irq(irq));
    ufu_afe_model u_ufu_afe_model (.clock(clock), .traffic(traffic), .unplugged(unplugged),
        .hs_termination_enable(hs_termination_enable), .afe_squelch_active_low(afe_squelch_active_low),
        .afe_disconnect(afe_disconnect));
    // 25 MHz clock
    always #20 clock = ~clock;
    // ==================================================================
    // Tasks
    // ==================================================================
    task tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end else begin
            q = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'b00;
        end
    endtask
    // One-cycle pulse on {protected, usb, lite, image load}
    task ctl(input logic [3:0] v);
        @(posedge clock);
        {protected_reset, usb_reset, lite_reset, image_load} <= v;
        @(posedge clock);
        {protected_reset, usb_reset, lite_reset, image_load} <= 4'h0;
        @(negedge clock);
    endtask
    // ==================================================================
    // Tests
    // ==================================================================
    initial begin
        {clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, traffic, unplugged} = '0;
        {protected_reset, usb_reset, lite_reset, image_load, eeprom_present, otp_programmed} = '0;
        {config_squelch_threshold, otp_squelch_threshold} = {3'h5, 3'h3};
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        wb(1'b0, ufu_pkg::CTRL_OFFSET, 4'hf, 32'h0, rd);
        `CHK("ctrl reset", 32'h1000_0000, rd)
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wb(1'b1, ufu_pkg::CTRL_OFFSET, 4'hf, {8'hf8 | 8'(i), 24'hff_ffff}, rd);
            wb(1'b0, ufu_pkg::CTRL_OFFSET, 4'hf, 32'h0, rd);
            `CHK("ctrl tune", {8'h30 | 8'(i), 24'h0}, rd)
            `CHK("tune pin", 3'(i), squelch_trip_tune)
        end
        wb(1'b1, ufu_pkg::CTRL_OFFSET, 4'h7, 32'h0, rd);
        wb(1'b0, ufu_pkg::CTRL_OFFSET, 4'hf, 32'h0, rd);
        `CHK("lane guard", 32'h3700_0000, rd)
        ctl(4'h8);
        `CHK("term protect", 1'b0, hs_termination_enable)
        `CHK("tune protect", 3'h7, squelch_trip_tune)
        $display("test fields done");
        wb(1'b1, ufu_pkg::CTRL_OFFSET, 4'h8, 32'h2000_0000, rd);
        @(posedge clock);
        traffic <= 1'b1;
        unplugged <= 1'b1;
        repeat (6) @(negedge clock);
        wb(1'b0, ufu_pkg::CTRL_OFFSET, 4'hf, 32'h0, rd);
        `CHK("ctrl pins", 32'h2800_0000, rd)
        `CHK("irq masked", 1'b0, irq)
        wb(1'b0, ufu_pkg::IRQ_STAT_OFFSET, 4'h1, 32'h0, rd);
        `CHK("status", 32'h3, rd)
        wb(1'b1, ufu_pkg::IRQ_MASK_OFFSET, 4'h1, 32'h3, rd);
        wb(1'b1, ufu_pkg::IRQ_STAT_OFFSET, 4'h1, 32'h1, rd);
        wb(1'b0, ufu_pkg::IRQ_STAT_OFFSET, 4'h1, 32'h0, rd);
        `CHK("status w1c", 32'h2, rd)
        `CHK("irq on", 1'b1, irq)
        wb(1'b1, ufu_pkg::IRQ_STAT_OFFSET, 4'h1, 32'h2, rd);
        @(negedge clock);
        `CHK("irq off", 1'b0, irq)
        $display("test pins done");
        for (i = 0; i < 3; i++) begin
            @(posedge clock);
            eeprom_present <= (i == 0);
            otp_programmed <= (i < 2);
            ctl(4'h1);
            `CHK("image", (i == 0) ? 3'h5 : (i == 1) ? 3'h3 : 3'h0, squelch_trip_tune)
        end
        @(posedge clock);
        eeprom_present <= 1'b1;
        ctl(4'h1);
        for (i = 1; i < 3; i++) begin
            wb(1'b1, ufu_pkg::CTRL_OFFSET, 4'h8, 32'h0200_0000, rd);
            @(negedge clock);
            `CHK("tune set", 3'h2, squelch_trip_tune)
            ctl(4'(1 << i));
            `CHK("restore", 3'h5, squelch_trip_tune)
        end
        wb(1'b1, 8'h40, 4'hf, 32'hffff_ffff, rd);
        wb(1'b0, 8'h40, 4'hf, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        $display("test image done");
        tally_and_finish();
    end
endmodule
